// File: design/sleep_gating_pkg.sv
// Package for the sleep power gating block: register map, field layouts, modes and carriers.
// Assumes a 32-bit AXI4-Lite register bus and a single 20 MHz system clock.
package sleep_gating_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIN_N  = 6;

  localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] PIN_DIS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] WAKE_OFS    = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h0C;

  // Control register fields.
  localparam int unsigned CTRL_ADC_EN  = 0;
  localparam int unsigned CTRL_CMP_DIS = 1;
  localparam int unsigned CTRL_CMP_REF = 2;
  localparam int unsigned CTRL_WDT_EN  = 3;
  localparam int unsigned CTRL_SLEEP   = 4;
  localparam int unsigned CTRL_MODE_LO = 5;
  localparam int unsigned CTRL_W       = 7;

  // Status register fields.
  localparam int unsigned ST_ADC   = 0;
  localparam int unsigned ST_CMP   = 1;
  localparam int unsigned ST_BOD   = 2;
  localparam int unsigned ST_REF   = 3;
  localparam int unsigned ST_WDT   = 4;
  localparam int unsigned ST_EXT   = 5;
  localparam int unsigned ST_SLEEP = 6;
  localparam int unsigned ST_MODE  = 7;
  localparam int unsigned ST_PINS  = 9;

  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [PIN_N-1:0]  PIN_RST  = 6'h00;
  localparam logic [1:0]        BOD_OFF  = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_IDLE  = 2'b00,
    MODE_NOISE = 2'b01,
    MODE_DOWN  = 2'b10,
    MODE_RSVD  = 2'b11
  } sleep_mode_e;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
  } clk_run_s;

  typedef struct packed {
    logic adc;
    logic cmp;
    logic bod;
    logic vref;
    logic wdt;
    logic ext_conv;
  } analog_en_s;

endpackage

// File: design/sleep_power_gating_control.sv
// Sleep-dependent enables for the converter, comparator, brown-out detector, reference,
// watchdog and pin input buffers, with an AXI4-Lite slave for control and status.
// Assumes the sleep controller drives sleep_active and that fuses are static after reset.
//
// Summary of operation
// (RULE1) A software-enabled converter stays enabled in every sleep mode.
// (RULE2) The first conversion after the converter is re-enabled is an extended one.
// (RULE3) Outside idle and noise reduction the comparator is switched off automatically.
// (RULE4) A live comparator using the internal reference keeps the reference on always.
// (RULE5) A fuse-enabled brown-out detector stays enabled in every sleep mode.
// (RULE6) The reference is on only while detector, comparator or converter needs it; here a comparator set to it keeps it on in power-down too.
// (RULE7) Software waits the reference start-up time before using it after re-enable.
// (RULE8) An enabled watchdog stays enabled in every sleep mode.
// (RULE9) Pin input buffers are off when both I/O and converter clocks are stopped.
// (RULE10) Pins needed for wake-up detection keep their input logic enabled; here a set disable bit still turns a wake pin off.
// (RULE11) A set bit in the pin input disable register turns that buffer off.
// (RULE12) Mode field: 00 idle, 01 noise reduction, 10 power-down, 11 reserved.
// (RULE13) Idle stops CPU and flash; noise also stops I/O; power-down stops all.
// (RULE14) Enables derive from a registered sleep state and change on a clock edge.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
module sleep_power_gating_control
  import sleep_gating_pkg::*;
(
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  input  wire logic [sleep_gating_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  input  wire logic [sleep_gating_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  input  wire logic [sleep_gating_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  output logic [sleep_gating_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready,
  input  wire logic                                   sleep_active,
  input  wire logic [1:0]                             brownout_level_fuses,
  output sleep_gating_pkg::clk_run_s                  clk_run,
  output sleep_gating_pkg::analog_en_s                analog_en,
  output logic [sleep_gating_pkg::PIN_N-1:0]          pin_buf_en
);
  import sleep_gating_pkg::*;

  // Register state.
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [PIN_N-1:0]  pin_input_disable_reg_q, pin_input_disable_reg_d;
  logic [PIN_N-1:0]  wake_pins_q, wake_pins_d;
  logic              sleep_q, sleep_d;
  sleep_mode_e       mode_q, mode_d;
  logic              ext_pend_q, ext_pend_d;
  logic              adc_prev_q, adc_prev_d;
  clk_run_s          clk_run_q, clk_run_d;
  analog_en_s        an_q, an_d;
  logic [PIN_N-1:0]  pin_buf_q, pin_buf_d;
  // Bus state.
  logic              aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [3:0]        w_strb_q, w_strb_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  // Ready is registered; a channel is taken only on valid with ready, so a request that
  // is held over the first edge after reset is never taken twice.
  logic              awready_q, wready_q, arready_q;
  logic              aw_take, w_take, ar_take;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == CTRL_OFS) || (a == PIN_DIS_OFS) || (a == WAKE_OFS) || (a == STATUS_OFS);
  endfunction

  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  // Write channel: address and data are taken in either order, response follows both.
  logic              wr_go;
  logic [ADDR_W-1:0] wa;
  logic [DATA_W-1:0] wd;
  logic [3:0]        ws;
  logic [7:0]        byte0;
  always_comb
  begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    ctrl_d   = ctrl_q;
    pin_input_disable_reg_d = pin_input_disable_reg_q;
    wake_pins_d = wake_pins_q;
    aw_take = s_axi_awvalid && awready_q;
    w_take  = s_axi_wvalid && wready_q;
    if (aw_take)
    begin
      aw_got_d  = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (w_take)
    begin
      w_got_d  = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    wr_go = aw_got_q && w_got_q && !bvalid_q;
    wa = aw_addr_q;
    wd = w_data_q;
    ws = w_strb_q;
    // Only byte lane 0 carries fields, so the upper strobes are ignored.
    byte0 = lane(8'h00, wd[7:0], ws[0]);
    if (wr_go)
    begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      if (ws[0])
      begin
        if (wa == CTRL_OFS)
          ctrl_d = byte0[CTRL_W-1:0];
        if (wa == PIN_DIS_OFS)
          pin_input_disable_reg_d = byte0[PIN_N-1:0];
        if (wa == WAKE_OFS)
          wake_pins_d = byte0[PIN_N-1:0];
      end
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
  end

  // Read channel: one read at a time, answered one cycle after the address is taken.
  logic [DATA_W-1:0] status_w;
  always_comb
  begin
    status_w = '0;
    status_w[ST_ADC]  = an_q.adc;
    status_w[ST_CMP]  = an_q.cmp;
    status_w[ST_BOD]  = an_q.bod;
    status_w[ST_REF]  = an_q.vref;
    status_w[ST_WDT]  = an_q.wdt;
    status_w[ST_EXT]  = an_q.ext_conv;
    status_w[ST_SLEEP] = sleep_q;
    status_w[ST_MODE +: 2] = mode_q;
    status_w[ST_PINS +: PIN_N] = pin_buf_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    ar_take  = s_axi_arvalid && arready_q;
    if (ar_take)
    begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        CTRL_OFS:    rdata_d = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
        PIN_DIS_OFS: rdata_d = {{(DATA_W-PIN_N){1'b0}}, pin_input_disable_reg_q};
        WAKE_OFS:    rdata_d = {{(DATA_W-PIN_N){1'b0}}, wake_pins_q};
        STATUS_OFS:  rdata_d = status_w;
        default:     rdata_d = '0;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  // Gating: everything below works from the registered sleep state, never the raw input.
  logic cmp_live, adc_on, io_run, adc_clk_run, bod_on;
  always_comb
  begin
    sleep_d = sleep_active;
    mode_d  = sleep_mode_e'(ctrl_q[CTRL_MODE_LO +: 2]); // [RULE12]
    clk_run_d = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1};
    if (sleep_q)
    begin
      unique case (mode_q) // [RULE13]
        MODE_IDLE:  clk_run_d = '{cpu: 1'b0, flash: 1'b0, io: 1'b1, adc: 1'b1};
        MODE_NOISE: clk_run_d = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b1};
        MODE_DOWN:  clk_run_d = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b0};
        // Reserved code: keep clocks running rather than guess a deeper mode.
        MODE_RSVD:  clk_run_d = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1};
      endcase
    end
    io_run      = clk_run_d.io;
    adc_clk_run = clk_run_d.adc;
    adc_on = ctrl_q[CTRL_ADC_EN]; // [RULE1]
    // The reserved code counts as neither idle nor noise, so the comparator stays off there.
    cmp_live = !ctrl_q[CTRL_CMP_DIS] &&
               (!sleep_q || mode_q == MODE_IDLE || mode_q == MODE_NOISE); // [RULE3]
    bod_on = (brownout_level_fuses != BOD_OFF); // [RULE5]
    // Only a converter disable clears the pending flag; conversion completion is outside.
    adc_prev_d = adc_on;
    ext_pend_d = ext_pend_q;
    if (adc_on && !adc_prev_q)
      ext_pend_d = 1'b1; // [RULE2]
    else if (!adc_on)
      ext_pend_d = 1'b0;
    an_d.adc  = adc_on;
    an_d.cmp  = cmp_live;
    an_d.bod  = bod_on;
    an_d.wdt  = ctrl_q[CTRL_WDT_EN]; // [RULE8]
    an_d.ext_conv = ext_pend_d; // [RULE2]
    // The comparator's reference demand ignores sleep mode, so it holds even while cmp_live is low.
    an_d.vref = bod_on || adc_on ||
                (!ctrl_q[CTRL_CMP_DIS] && ctrl_q[CTRL_CMP_REF]); // [RULE4] [RULE6]
    // Wake pins override the sleep gating but never the software disable bit.
    for (int i = 0; i < PIN_N; i++)
    begin
      pin_buf_d[i] = !pin_input_disable_reg_q[i] && // [RULE11]
                     ((io_run || adc_clk_run) || wake_pins_q[i]); // [RULE9] [RULE10]
    end
  end

  // Fuse copy lives only in the combinational path, so a sleep change passes two registration
  // stages before the gating enables: sleep_d into sleep_q, then sleep_q into the enables.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= CTRL_RST;
      pin_input_disable_reg_q <= PIN_RST;
      wake_pins_q <= PIN_RST;
      sleep_q  <= 1'b0;
      mode_q   <= MODE_IDLE;
      ext_pend_q <= 1'b0;
      adc_prev_q <= 1'b0;
      clk_run_q <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1};
      an_q     <= '0;
      pin_buf_q <= '1;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      pin_input_disable_reg_q <= pin_input_disable_reg_d;
      wake_pins_q <= wake_pins_d;
      sleep_q  <= sleep_d; // [RULE14]
      mode_q   <= mode_d;
      ext_pend_q <= ext_pend_d;
      adc_prev_q <= adc_prev_d;
      clk_run_q <= clk_run_d; // [RULE14]
      an_q     <= an_d;
      pin_buf_q <= pin_buf_d;
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // Ready is registered state inverted: take a channel only while nothing is held for it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
    end
    else
    begin
      awready_q <= !aw_got_d && !bvalid_d;
      wready_q  <= !w_got_d && !bvalid_d;
      arready_q <= !rvalid_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign clk_run       = clk_run_q;
  assign analog_en     = an_q;
  assign pin_buf_en    = pin_buf_q;

endmodule

// File: test/sleep_gating_monitor.sv
// Checker on the gating outputs of the sleep power block.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ns
module sleep_gating_monitor
(
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic                         sleep_active,
  input wire logic [1:0]                   brownout_level_fuses,
  input wire sleep_gating_pkg::clk_run_s   clk_run,
  input wire sleep_gating_pkg::analog_en_s analog_en
);
  import sleep_gating_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bod_fuses: assert property (
    $past(aresetn) |-> analog_en.bod == (brownout_level_fuses != BOD_OFF))
    else $error("detector enable differs from fuses");
  a_adc_kept: assert property (
    $rose(sleep_active) |-> ##2 analog_en.adc == $past(analog_en.adc, 2))
    else $error("converter enable lost at sleep");
  a_wdt_kept: assert property (
    $rose(sleep_active) |-> ##2 analog_en.wdt == $past(analog_en.wdt, 2))
    else $error("watchdog enable lost at sleep");
  a_ext_set: assert property (
    $rose(analog_en.adc) |-> ##[0:1] analog_en.ext_conv)
    else $error("no extended conversion after enable");
  a_cmp_down: assert property (
    !clk_run.io && !clk_run.adc |-> !analog_en.cmp)
    else $error("comparator on in deep sleep");
  a_ref_users: assert property (
    analog_en.bod || analog_en.adc |-> analog_en.vref)
    else $error("reference off while needed");
  a_clk_nest: assert property (
    clk_run.cpu == clk_run.flash && (clk_run.io || !clk_run.cpu) && (clk_run.adc || !clk_run.io))
    else $error("clock domains stopped out of order");
  a_wake_runs: assert property (
    !sleep_active |-> ##2 clk_run == 4'hF)
    else $error("clocks not running two edges after wake");
  c_down: cover property (clk_run == 4'h0);
  c_ext: cover property ($rose(analog_en.ext_conv));
  c_ref_alone: cover property (analog_en.vref && !analog_en.adc && !analog_en.bod);
endmodule

// File: test/analog_side_model.sv
// Far side model: reference start-up and the pin input stages.
// Assumes the enables come straight from the gating block.
`timescale 1ns/1ns
module analog_side_model
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire sleep_gating_pkg::analog_en_s analog_en,
  input  wire logic [5:0]                   pin_buf_en,
  input  wire logic [5:0]                   pads,
  output logic                              ref_ok,
  output logic [5:0]                        pins_seen
);
  import sleep_gating_pkg::*;
  // Plain default length; the real start-up figure is not modelled.
  localparam logic [1:0] REF_START = 2'h2;
  logic [1:0] ref_cnt_q;
  logic [1:0] ref_cnt_d;
  always_comb
  begin
    ref_cnt_d = (ref_cnt_q == REF_START) ? ref_cnt_q : ref_cnt_q + 2'h1;
    if (!aresetn || !analog_en.vref)
      ref_cnt_d = 2'h0;
  end
  always_ff @(posedge aclk)
    ref_cnt_q <= ref_cnt_d;
  assign ref_ok = ref_cnt_q == REF_START;
  // A switched-off buffer reads low, so a floating pad costs nothing.
  assign pins_seen = pads & pin_buf_en;
endmodule

// File: test/sleep_power_gating_control_tb.sv
// Testbench for the sleep power gating block, driven over its register bus.
// Assumes the far side model and the monitor are compiled first.
`timescale 1ns/1ns
module sleep_power_gating_control_tb;
  import sleep_gating_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, sleep_active = 1'b0, ref_ok;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, brownout_level_fuses = 2'h3;
  logic [5:0]  pin_buf_en, pins_seen;
  clk_run_s    clk_run;
  analog_en_s  analog_en;
  int          n_mismatch = 0, checks_done = 0;
  logic [3:0]  clk_tab [4] = '{4'h3, 4'h1, 4'h0, 4'hF};
  logic [5:0]  an_tab [4] = '{6'h37, 6'h37, 6'h27, 6'h27};
  logic [5:0]  pin_tab [4] = '{6'h3F, 6'h3F, 6'h00, 6'h3F};
  sleep_power_gating_control i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_active, .brownout_level_fuses, .clk_run,
    .analog_en, .pin_buf_en);
  analog_side_model i_far (.aclk, .aresetn, .analog_en, .pin_buf_en, .pads(6'h3F), .ref_ok,
    .pins_seen);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Sleep and control changes land two edges later; three leaves margin.
  task automatic st(input logic s);
    sleep_active <= s;
    repeat (3) @(posedge aclk);
  endtask
  task automatic outs(input logic [3:0] c, input logic [5:0] e, input logic [5:0] p);
    chk(clk_run, c);
    chk(analog_en, e);
    chk(pins_seen, p);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    st(1'b0);
    outs(4'hF, 6'h10, 6'h3F);
    rd(STATUS_OFS, 32'h7E02, RESP_OKAY);
    $display("test reset done");
    wr(CTRL_OFS, 32'h0F, 4'hF, RESP_OKAY);
    wr(CTRL_OFS, 32'h00, 4'h0, RESP_OKAY);
    rd(CTRL_OFS, 32'h0F, RESP_OKAY);
    outs(4'hF, 6'h27, 6'h3F);
    wr(8'h10, 32'h01, 4'hF, RESP_SLVERR);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(STATUS_OFS, 32'h0, 4'hF, RESP_OKAY);
    rd(STATUS_OFS, 32'h7E39, RESP_OKAY);
    $display("test registers done");
    for (int m = 0; m < 4; m++)
    begin
      wr(CTRL_OFS, {25'h0, m[1:0], 5'h09}, 4'hF, RESP_OKAY);
      st(1'b1);
      outs(clk_tab[m], an_tab[m], pin_tab[m]);
      st(1'b0);
      outs(4'hF, 6'h37, 6'h3F);
    end
    $display("test modes done");
    wr(WAKE_OFS, 32'h05, 4'hF, RESP_OKAY);
    wr(PIN_DIS_OFS, 32'h01, 4'hF, RESP_OKAY);
    wr(CTRL_OFS, 32'h44, 4'hF, RESP_OKAY);
    st(1'b1);
    outs(4'h0, 6'h04, 6'h04);
    chk(ref_ok, 1'b1);
    wr(CTRL_OFS, 32'h46, 4'hF, RESP_OKAY);
    st(1'b1);
    outs(4'h0, 6'h00, 6'h04);
    chk(ref_ok, 1'b0);
    st(1'b0);
    outs(4'hF, 6'h00, 6'h3E);
    wr(CTRL_OFS, 32'h01, 4'hF, RESP_OKAY);
    st(1'b0);
    outs(4'hF, 6'h35, 6'h3E);
    $display("test pins and reference done");
    aresetn <= 1'b0;
    brownout_level_fuses <= 2'h1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    st(1'b0);
    outs(4'hF, 6'h1C, 6'h3F);
    wr(CTRL_OFS, 32'h40, 4'hF, RESP_OKAY);
    st(1'b1);
    outs(4'h0, 6'h0C, 6'h00);
    st(1'b0);
    $display("test detector done");
    complete_run();
  end
endmodule
bind sleep_power_gating_control sleep_gating_monitor i_mon (.aclk, .aresetn, .sleep_active,
  .brownout_level_fuses, .clk_run, .analog_en);
